// *** rtl/mpc_command_interp.sv ***
// mailbox command interpreter with two pulse generators and input pattern match
//
// Contract
// RULE1: code 0E returns firmware version, 0F hardware version, high byte in result high.
// RULE2: every accepted command echoes its code and reports current input levels.
// RULE3: codes 10/11 load generator 0 high/low time; 12/13 generator 1.
// RULE4: period value is parameter high byte times 256 plus low byte.
// RULE5: one period unit is 100 ms; waveform period is high plus low time.
// RULE6: codes 14/15 load the 16-bit burst count of generator 0/1.
// RULE7: burst count zero runs continuously; nonzero gives that many cycles.
// RULE8: code 1F enables generator 0 by bit 0, generator 1 by bit 1.
// RULE9: host writes zero to bits 2 to 7 of the enable parameter.
// RULE10: on enable, zero burst runs forever, nonzero emits count cycles then stops.
// RULE11: code 20 sets filter enable of input n from parameter bit n.
// RULE12: code 21 sets pattern match enable of input n from bit n.
// RULE13: code 22 stores parameter low byte as pattern match reference.
// RULE14: match ignores reference bits of inputs whose match enable is clear.
// RULE15: echo takes the command code only once the command is accepted.
// RULE16: reported input levels refresh every 100 us.
// RULE17: code 00 clears the echo byte to zero.
// RULE18: host writes parameters before the code and waits for the echo.
// RULE19: disabled generator output is low; enabled generator starts high.
module mpc_command_interp
   import mpc_pkg::*;
#(
   parameter int          UNIT_CYCLES_P = UNIT_CYCLES,  // clock cycles per period unit
   parameter logic [15:0] FW_VERSION    = 16'h0102,     // arbitrary value
   parameter logic [15:0] HW_VERSION    = 16'h0304      // arbitrary value
)
(
   input  wire logic          clk,           // 20 MHz clock
   input  wire logic          resetn,        // asynchronous reset, active low
   input  wire logic          cmdValid,      // one-cycle strobe: outMbox holds a command
   input  wire mpc_out_mbox_t outMbox,       // outgoing mailbox bytes from the host
   input  wire logic [7:0]    isolatedInput, // input pins, asynchronous
   output mpc_in_mbox_t       inMbox,        // incoming mailbox bytes to the host
   output logic [1:0]         pulseGenOut,   // pulse generator outputs
   output logic [7:0]         filterEnable,  // per-input filter enables
   output logic [7:0]         matchEnable,   // per-input pattern match enables
   output logic [7:0]         matchValue,    // pattern match reference
   output logic               patternMatch   // enabled inputs equal the reference
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   localparam logic [UNIT_CNT_W-1:0] UNIT_LAST    = UNIT_CNT_W'(UNIT_CYCLES_P - 1);
   localparam logic [REFRESH_W-1:0]  REFRESH_LAST = REFRESH_W'(REFRESH_CYCLES - 1);

   mpc_state_t state_q;
   mpc_state_t state_d;
   logic       cmdKnown;
   logic [15:0] paramWord;

   assign paramWord = {outMbox.paramHigh, outMbox.paramLow}; // RULE4

   always_comb
   begin
      case (outMbox.command)
         CMD_CLEAR_ECHO, CMD_FW_VERSION, CMD_HW_VERSION, CMD_GEN0_HIGH, CMD_GEN0_LOW,
         CMD_GEN1_HIGH, CMD_GEN1_LOW, CMD_GEN0_BURST, CMD_GEN1_BURST, CMD_GEN_ENABLE,
         CMD_FILTER_EN, CMD_MATCH_EN, CMD_MATCH_VALUE: cmdKnown = 1'b1;
         default:                                       cmdKnown = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [15:0] phaseLen;
      phaseLen = RST_WORD;
      state_d  = state_q;

      // input synchroniser and periodic level snapshot
      state_d.syncA = isolatedInput;
      state_d.syncB = state_q.syncA;
      if (state_q.refreshCnt == REFRESH_LAST)
      begin
         state_d.refreshCnt         = '0;
         state_d.inMbox.inputLevels = state_q.syncB; // RULE16 RULE2
      end
      else
      begin
         state_d.refreshCnt = state_q.refreshCnt + REFRESH_W'(1);
      end

      // pulse generators run
      for (int i = 0; i < 2; i++)
      begin
         if (state_q.gen[i].enable)
         begin
            if (state_q.gen[i].unitCnt == UNIT_LAST) // RULE5
            begin
               state_d.gen[i].unitCnt = '0;
               phaseLen = state_q.gen[i].highPhase ? state_q.gen[i].highTime
                                                   : state_q.gen[i].lowTime;
               if ({1'b0, state_q.gen[i].phaseCnt} + 17'h00001 >= {1'b0, phaseLen})
               begin
                  state_d.gen[i].phaseCnt  = RST_WORD;
                  state_d.gen[i].highPhase = !state_q.gen[i].highPhase;
                  // end of a low phase closes one cycle
                  if (!state_q.gen[i].highPhase && state_q.gen[i].burstCount != RST_WORD)
                  begin
                     state_d.gen[i].burstLeft = state_q.gen[i].burstLeft - 16'h0001; // RULE7
                     if (state_q.gen[i].burstLeft <= 16'h0001)
                     begin
                        state_d.gen[i].enable = 1'b0; // RULE10
                     end
                  end
               end
               else
               begin
                  state_d.gen[i].phaseCnt = state_q.gen[i].phaseCnt + 16'h0001;
               end
            end
            else
            begin
               state_d.gen[i].unitCnt = state_q.gen[i].unitCnt + UNIT_CNT_W'(1);
            end
         end
      end

      // command execution
      if (cmdValid && cmdKnown)
      begin
         state_d.inMbox.echo = outMbox.command; // RULE15 RULE2 RULE17
         case (outMbox.command)
            CMD_FW_VERSION:
            begin
               {state_d.inMbox.resultHigh, state_d.inMbox.resultLow} = FW_VERSION; // RULE1
            end
            CMD_HW_VERSION:
            begin
               {state_d.inMbox.resultHigh, state_d.inMbox.resultLow} = HW_VERSION; // RULE1
            end
            CMD_GEN0_HIGH:   state_d.gen[0].highTime   = paramWord; // RULE3
            CMD_GEN0_LOW:    state_d.gen[0].lowTime    = paramWord; // RULE3
            CMD_GEN1_HIGH:   state_d.gen[1].highTime   = paramWord; // RULE3
            CMD_GEN1_LOW:    state_d.gen[1].lowTime    = paramWord; // RULE3
            CMD_GEN0_BURST:  state_d.gen[0].burstCount = paramWord; // RULE6
            CMD_GEN1_BURST:  state_d.gen[1].burstCount = paramWord; // RULE6
            CMD_GEN_ENABLE:
            begin
               for (int i = 0; i < 2; i++)
               begin
                  state_d.gen[i].enable = outMbox.paramLow[i]; // RULE8
                  if (outMbox.paramLow[i])
                  begin
                     state_d.gen[i].highPhase = 1'b1; // RULE19
                     state_d.gen[i].unitCnt   = '0;
                     state_d.gen[i].phaseCnt  = RST_WORD;
                     state_d.gen[i].burstLeft = state_q.gen[i].burstCount; // RULE10
                  end
               end
            end
            CMD_FILTER_EN:   state_d.filterEn   = outMbox.paramLow; // RULE11
            CMD_MATCH_EN:    state_d.matchEn    = outMbox.paramLow; // RULE12
            CMD_MATCH_VALUE: state_d.matchValue = outMbox.paramLow; // RULE13
            default:         state_d.inMbox.echo = outMbox.command;
         endcase
      end

      for (int i = 0; i < 2; i++)
      begin
         state_d.pulseOut[i] = state_d.gen[i].enable & state_d.gen[i].highPhase; // RULE19
      end
      // only enabled inputs take part
      state_d.matchHit = ((state_q.syncB ^ state_q.matchValue) & state_q.matchEn) == 8'h00; // RULE14
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign inMbox       = state_q.inMbox;
   assign pulseGenOut  = state_q.pulseOut;
   assign filterEnable = state_q.filterEn;
   assign matchEnable  = state_q.matchEn;
   assign matchValue   = state_q.matchValue;
   assign patternMatch = state_q.matchHit;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_cmd(logic [7:0] code);
      cmdValid && outMbox.command == code;
   endsequence

   sequence s_enable_cmd(int ch, logic bitVal);
      s_cmd(CMD_GEN_ENABLE) ##0 outMbox.paramLow[ch] == bitVal;
   endsequence

   a_echo_update: assert property (@(posedge clk) disable iff (!resetn) // RULE15
      cmdValid && cmdKnown |=> inMbox.echo == $past(outMbox.command))
      else $error("echo does not follow accepted command");

   a_echo_hold: assert property (@(posedge clk) disable iff (!resetn) // RULE15
      !$stable(inMbox.echo) |-> $past(cmdValid) && $past(cmdKnown))
      else $error("echo changed without a command");

   a_fw_version: assert property (@(posedge clk) disable iff (!resetn) // RULE1
      s_cmd(CMD_FW_VERSION) |=> {inMbox.resultHigh, inMbox.resultLow} == FW_VERSION)
      else $error("firmware version not returned");

   a_hw_version: assert property (@(posedge clk) disable iff (!resetn) // RULE1
      s_cmd(CMD_HW_VERSION) |=> {inMbox.resultHigh, inMbox.resultLow} == HW_VERSION)
      else $error("hardware version not returned");

   a_period_load: assert property (@(posedge clk) disable iff (!resetn) // RULE3
      s_cmd(CMD_GEN1_LOW) |=> state_q.gen[1].lowTime == $past(paramWord))
      else $error("generator 1 low time not loaded");

   a_burst_load: assert property (@(posedge clk) disable iff (!resetn) // RULE6
      s_cmd(CMD_GEN0_BURST) |=> state_q.gen[0].burstCount == $past(paramWord))
      else $error("generator 0 burst count not loaded");

   a_enable_starts: assert property (@(posedge clk) disable iff (!resetn) // RULE19
      s_enable_cmd(0, 1'b1) |=> pulseGenOut[0] ##1 pulseGenOut[0])
      else $error("enabled generator does not start high");

   a_disable_low: assert property (@(posedge clk) disable iff (!resetn) // RULE8
      s_enable_cmd(1, 1'b0) |=> !pulseGenOut[1] && !state_q.gen[1].enable)
      else $error("disabled generator output not low");

   a_burst_stop: assert property (@(posedge clk) disable iff (!resetn) // RULE10
      $fell(state_q.gen[0].enable) && !$past(cmdValid) |->
         $past(state_q.gen[0].burstLeft) == 16'h0001 && state_q.gen[0].burstCount != RST_WORD)
      else $error("generator stopped before its burst finished");

   a_filter_set: assert property (@(posedge clk) disable iff (!resetn) // RULE11
      s_cmd(CMD_FILTER_EN) |=> filterEnable == $past(outMbox.paramLow))
      else $error("filter enables not loaded");

   a_match_ref: assert property (@(posedge clk) disable iff (!resetn) // RULE13
      s_cmd(CMD_MATCH_VALUE) |=> matchValue == $past(outMbox.paramLow))
      else $error("match reference not loaded");

   a_match_mask: assert property (@(posedge clk) disable iff (!resetn) // RULE14
      matchEnable == 8'h00 && $past(matchEnable) == 8'h00 |=> patternMatch)
      else $error("match without enabled inputs not true");

   a_levels_refresh: assert property (@(posedge clk) disable iff (!resetn) // RULE16
      !$stable(inMbox.inputLevels) |-> $past(state_q.refreshCnt) == REFRESH_LAST)
      else $error("input levels changed off the refresh tick");

   a_gen0_high_load: assert property (@(posedge clk) disable iff (!resetn) // RULE3
      s_cmd(CMD_GEN0_HIGH) |=> state_q.gen[0].highTime == $past(paramWord))
      else $error("generator 0 high time not loaded");

   a_gen0_low_load: assert property (@(posedge clk) disable iff (!resetn) // RULE3
      s_cmd(CMD_GEN0_LOW) |=> state_q.gen[0].lowTime == $past(paramWord))
      else $error("generator 0 low time not loaded");

   a_gen1_high_load: assert property (@(posedge clk) disable iff (!resetn) // RULE3
      s_cmd(CMD_GEN1_HIGH) |=> state_q.gen[1].highTime == $past(paramWord))
      else $error("generator 1 high time not loaded");

   a_burst1_load: assert property (@(posedge clk) disable iff (!resetn) // RULE6
      s_cmd(CMD_GEN1_BURST) |=> state_q.gen[1].burstCount == $past(paramWord))
      else $error("generator 1 burst count not loaded");

   a_match_en_set: assert property (@(posedge clk) disable iff (!resetn) // RULE12
      s_cmd(CMD_MATCH_EN) |=> matchEnable == $past(outMbox.paramLow))
      else $error("match enables not loaded");

   a_echo_clear: assert property (@(posedge clk) disable iff (!resetn) // RULE17
      s_cmd(CMD_CLEAR_ECHO) |=> inMbox.echo == 8'h00)
      else $error("echo not cleared");

   a_unknown_ignored: assert property (@(posedge clk) disable iff (!resetn) // RULE15
      cmdValid && !cmdKnown |=> $stable(inMbox.echo))
      else $error("unknown code changed the echo");

   a_result_hold: assert property (@(posedge clk) disable iff (!resetn) // RULE1
      !(cmdValid && (outMbox.command == CMD_FW_VERSION || outMbox.command == CMD_HW_VERSION))
         |=> $stable(inMbox.resultHigh) && $stable(inMbox.resultLow))
      else $error("result bytes changed without a version command");

   a_gen0_phase_unit: assert property (@(posedge clk) disable iff (!resetn) // RULE5
      $changed(pulseGenOut[0]) && !$past(cmdValid) |->
         $past(state_q.gen[0].unitCnt) == UNIT_LAST)
      else $error("generator 0 output moved off a unit boundary");

   a_gen1_phase_unit: assert property (@(posedge clk) disable iff (!resetn) // RULE5
      $changed(pulseGenOut[1]) && !$past(cmdValid) |->
         $past(state_q.gen[1].unitCnt) == UNIT_LAST)
      else $error("generator 1 output moved off a unit boundary");

   a_gen1_continuous: assert property (@(posedge clk) disable iff (!resetn) // RULE7
      state_q.gen[1].enable && state_q.gen[1].burstCount == RST_WORD && !cmdValid
         |=> state_q.gen[1].enable)
      else $error("continuous generator 1 stopped by itself");

   a_gen1_burst_start: assert property (@(posedge clk) disable iff (!resetn) // RULE10
      s_enable_cmd(1, 1'b1) |=>
         state_q.gen[1].burstLeft == $past(state_q.gen[1].burstCount) && pulseGenOut[1])
      else $error("generator 1 did not start its burst");

   a_gen1_burst_stop: assert property (@(posedge clk) disable iff (!resetn) // RULE10
      $fell(state_q.gen[1].enable) && !$past(cmdValid) |->
         $past(state_q.gen[1].burstLeft) == 16'h0001 && state_q.gen[1].burstCount != RST_WORD)
      else $error("generator 1 stopped before its burst finished");

   a_levels_snapshot: assert property (@(posedge clk) disable iff (!resetn) // RULE16
      $past(state_q.refreshCnt) == REFRESH_LAST |->
         inMbox.inputLevels == $past(state_q.syncB))
      else $error("input levels not taken on the refresh tick");

endmodule : mpc_command_interp

// *** rtl/mpc_pkg.sv ***
// package: mailbox command codes, timing constants and carrier types
package mpc_pkg;

   // ----------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_CLEAR_ECHO  = 8'h00;
   localparam logic [7:0] CMD_FW_VERSION  = 8'h0E;
   localparam logic [7:0] CMD_HW_VERSION  = 8'h0F;
   localparam logic [7:0] CMD_GEN0_HIGH   = 8'h10;
   localparam logic [7:0] CMD_GEN0_LOW    = 8'h11;
   localparam logic [7:0] CMD_GEN1_HIGH   = 8'h12;
   localparam logic [7:0] CMD_GEN1_LOW    = 8'h13;
   localparam logic [7:0] CMD_GEN0_BURST  = 8'h14;
   localparam logic [7:0] CMD_GEN1_BURST  = 8'h15;
   localparam logic [7:0] CMD_GEN_ENABLE  = 8'h1F;
   localparam logic [7:0] CMD_FILTER_EN   = 8'h20;
   localparam logic [7:0] CMD_MATCH_EN    = 8'h21;
   localparam logic [7:0] CMD_MATCH_VALUE = 8'h22;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ         = 20_000_000;
   localparam int UNIT_MS        = 100;
   localparam int UNIT_CYCLES    = UNIT_MS * (CLK_HZ / 1000);
   localparam int REFRESH_US     = 100;
   localparam int REFRESH_CYCLES = REFRESH_US * (CLK_HZ / 1_000_000);
   localparam int UNIT_CNT_W     = 24;
   localparam int REFRESH_W      = 12;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;

   // ----------------------------------------------------------------
   // carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] reserved;
      logic [7:0] command;
      logic [7:0] paramHigh;
      logic [7:0] paramLow;
   } mpc_out_mbox_t;

   typedef struct packed {
      logic [7:0] inputLevels;
      logic [7:0] echo;
      logic [7:0] resultHigh;
      logic [7:0] resultLow;
   } mpc_in_mbox_t;

   typedef struct packed {
      logic                  enable;
      logic                  highPhase;
      logic [UNIT_CNT_W-1:0] unitCnt;
      logic [15:0]           phaseCnt;
      logic [15:0]           highTime;
      logic [15:0]           lowTime;
      logic [15:0]           burstCount;
      logic [15:0]           burstLeft;
   } mpc_pulse_gen_t;

   typedef struct packed {
      mpc_pulse_gen_t [1:0]  gen;
      logic [7:0]            syncA;
      logic [7:0]            syncB;
      logic [REFRESH_W-1:0]  refreshCnt;
      mpc_in_mbox_t          inMbox;
      logic [7:0]            filterEn;
      logic [7:0]            matchEn;
      logic [7:0]            matchValue;
      logic                  matchHit;
      logic [1:0]            pulseOut;
   } mpc_state_t;

endpackage : mpc_pkg

// *** bench/mpc_command_interp_test.sv ***
// self-checking testbench for the mailbox command interpreter
module mpc_command_interp_test
   import mpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int          UNIT   = 4;
   localparam logic [15:0] FW_VER = 16'h1A2B;  // arbitrary value
   localparam logic [15:0] HW_VER = 16'h3C4D;  // arbitrary value

   logic          clk;
   logic          resetn;
   logic          cmdValid;
   mpc_out_mbox_t outMbox;
   logic [7:0]    isolatedInput;
   mpc_in_mbox_t  inMbox;
   logic [1:0]    pulseGenOut;
   logic [7:0]    filterEnable;
   logic [7:0]    matchEnable;
   logic [7:0]    matchValue;
   logic          patternMatch;
   int            fail_count;
   int            checks_done;
   int            cycles;
   int            n;

   mpc_command_interp #(.UNIT_CYCLES_P(UNIT), .FW_VERSION(FW_VER), .HW_VERSION(HW_VER)) i_dut (
      .clk          (clk),
      .resetn       (resetn),
      .cmdValid     (cmdValid),
      .outMbox      (outMbox),
      .isolatedInput(isolatedInput),
      .inMbox       (inMbox),
      .pulseGenOut  (pulseGenOut),
      .filterEnable (filterEnable),
      .matchEnable  (matchEnable),
      .matchValue   (matchValue),
      .patternMatch (patternMatch)
   );

   // ----------------------------------------------------------------
   // clock and hang guard
   // ----------------------------------------------------------------
   initial clk = 1'b0;
   always #25 clk = ~clk;

   initial cycles = 0;
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         fail_count++;
         results();
      end
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask : check

   // one-cycle strobe, echo judged after the taking edge, one idle cycle after
   task automatic cmd(input logic [7:0] code, input logic [15:0] prm, input logic [7:0] echo);
      outMbox  = {8'h00, code, prm};
      cmdValid = 1'b1;
      @(negedge clk);
      cmdValid = 1'b0;
      check("echo", echo, inMbox.echo);
      @(negedge clk);
   endtask : cmd

   task automatic measure(input int idx, input logic lvl, input int lim, output int cnt);
      cnt = 0;
      while (pulseGenOut[idx] === lvl && cnt < lim)
      begin
         cnt++;
         @(negedge clk);
      end
   endtask : measure

   task automatic results();
      $display("mismatches %0d comparisons %0d", fail_count, checks_done);
      if (fail_count == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      check("mailbox", 32'h0, inMbox);
      check("pulses", 2'b00, pulseGenOut);
      check("enables", 24'h0, {filterEnable, matchEnable, matchValue});
      repeat (2) @(negedge clk);
      check("match idle", 1'b1, patternMatch);
   endtask : t_reset

   task automatic t_versions();
      cmd(CMD_FW_VERSION, 16'hFFFF, CMD_FW_VERSION);
      check("fw version", FW_VER, {inMbox.resultHigh, inMbox.resultLow});
      cmd(CMD_HW_VERSION, 16'h0000, CMD_HW_VERSION);
      check("hw version", HW_VER, {inMbox.resultHigh, inMbox.resultLow});
      cmd(CMD_CLEAR_ECHO, 16'h0000, 8'h00);
      cmd(8'h07, 16'h0000, 8'h00);
      cmd(CMD_HW_VERSION, 16'h0000, CMD_HW_VERSION);
   endtask : t_versions

   task automatic t_inputs();
      cmd(CMD_FILTER_EN, 16'hFF11, CMD_FILTER_EN);
      check("filter enable", 8'h11, filterEnable);
      cmd(CMD_MATCH_EN, 16'hFF3A, CMD_MATCH_EN);
      check("match enable", 8'h3A, matchEnable);
      cmd(CMD_MATCH_VALUE, 16'hFF28, CMD_MATCH_VALUE);
      check("match value", 8'h28, matchValue);
      // excluded inputs differ from the reference, included ones agree
      isolatedInput = 8'hED;
      repeat (4) @(negedge clk);
      check("match hit", 1'b1, patternMatch);
      isolatedInput = 8'hEF;
      repeat (4) @(negedge clk);
      check("match miss", 1'b0, patternMatch);
      isolatedInput = 8'h5C;
      repeat (2005) @(negedge clk);
      check("input levels", 8'h5C, inMbox.inputLevels);
   endtask : t_inputs

   task automatic t_burst();
      cmd(CMD_GEN0_HIGH, 16'h0002, CMD_GEN0_HIGH);
      cmd(CMD_GEN0_LOW, 16'h0003, CMD_GEN0_LOW);
      cmd(CMD_GEN0_BURST, 16'h0002, CMD_GEN0_BURST);
      cmd(CMD_GEN_ENABLE, 16'h0001, CMD_GEN_ENABLE);
      measure(0, 1'b1, 3000, n);
      check("gen0 high 1", 2 * UNIT - 1, n);
      measure(0, 1'b0, 3000, n);
      check("gen0 low 1", 3 * UNIT, n);
      measure(0, 1'b1, 3000, n);
      check("gen0 high 2", 2 * UNIT, n);
      measure(0, 1'b0, 60, n);
      check("gen0 stopped", 60, n);
   endtask : t_burst

   task automatic t_continuous();
      cmd(CMD_GEN1_HIGH, 16'h0101, CMD_GEN1_HIGH);
      cmd(CMD_GEN1_LOW, 16'h0001, CMD_GEN1_LOW);
      cmd(CMD_GEN1_BURST, 16'h0000, CMD_GEN1_BURST);
      cmd(CMD_GEN_ENABLE, 16'h0002, CMD_GEN_ENABLE);
      check("gen0 off", 1'b0, pulseGenOut[0]);
      measure(1, 1'b1, 3000, n);
      check("gen1 high 1", 257 * UNIT - 1, n);
      measure(1, 1'b0, 3000, n);
      check("gen1 low 1", UNIT, n);
      measure(1, 1'b1, 3000, n);
      check("gen1 high 2", 257 * UNIT, n);
      measure(1, 1'b0, 3000, n);
      check("gen1 low 2", UNIT, n);
      check("gen1 runs on", 1'b1, pulseGenOut[1]);
      cmd(CMD_GEN_ENABLE, 16'h0000, CMD_GEN_ENABLE);
      check("both off", 2'b00, pulseGenOut);
   endtask : t_continuous

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      fail_count    = 0;
      checks_done   = 0;
      resetn        = 1'b0;
      cmdValid      = 1'b0;
      outMbox       = 32'h0;
      isolatedInput = 8'h00;
      repeat (8) @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      t_reset();
      t_versions();
      t_inputs();
      t_burst();
      t_continuous();
      results();
   end

endmodule : mpc_command_interp_test
